// *** rtl/adc_pkg.sv ***
package adc_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_RESET_CONTROL = 8'h01;
  localparam logic [7:0] ADDR_OUTPUT_STAGE = 8'h02;
  localparam logic [7:0] ADDR_POWER_STATE = 8'h03;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_RESET_CONTROL = 8'h00;
  localparam logic [7:0] RST_OUTPUT_STAGE = 8'h00;
  localparam logic [7:0] RST_POWER_STATE = 8'h10;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CORE_RESET_BIT = 4;
  localparam int REG_RESET_BIT = 0;
  localparam logic [7:0] RESET_CTRL_RW_MASK = 8'hE0;
  localparam int RATE_LSB = 4;
  localparam int BRIDGE_BIT = 2;
  localparam int MOD_LSB = 0;
  localparam int DSP_HOLD_BIT = 4;
  localparam int MUTE_BIT = 3;
  localparam int PSTATE_LSB = 0;

  // ------------------------------------------------------------
  // enumerations
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    RATE_768K = 3'h0,
    RATE_384K = 3'h1,
    RATE_480K = 3'h3,
    RATE_576K = 3'h4
  } adc_rate_t;

  typedef enum logic [1:0] {
    MOD_BD = 2'h0,
    MOD_SINGLE_SIDED = 2'h1,
    MOD_HYBRID = 2'h2
  } adc_mod_t;

  typedef enum logic [1:0] {
    PS_DEEP_SLEEP = 2'h0,
    PS_SLEEP = 2'h1,
    PS_HIZ = 2'h2,
    PS_PLAY = 2'h3
  } adc_pstate_t;

  // register access from the control port
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adc_req_t;

  // decoded control outputs
  typedef struct packed {
    logic [2:0] switching_rate_select;
    logic rate_reserved;
    logic bridge_parallel_select;
    logic [1:0] modulation_scheme;
    logic dsp_hold;
    logic mute;
    logic [1:0] power_state;
  } adc_ctrl_t;

endpackage : adc_pkg

// *** rtl/adc_device_control_regs.sv ***
//
// Contract
// (R1) writing 1 to core_reset_bit resets whole digital chain; bit self-clears
// (R2) a core reset makes the dsp wipe the coefficient ram
// (R3) writing 1 to bit 0 restores register defaults, ram kept; self-clears
// (R4) bits 6-4 pick switching rate 768/384/480/576 kHz; other codes reserved
// (R5) bridge_parallel_select 0 selects btl, 1 selects parallel btl
// (R6) modulation_scheme 00 bd, 01 single sided, 10 hybrid
// (R7) dsp_hold resets to 1; clearing it powers up the dsp
// (R8) host clears dsp_hold only after audio clocks are stable
// (R9) mute bit requests soft ramp down; clearing ramps volume back up
// (R10) power state 00 deep sleep, 01 sleep, 10 hi-z, 11 play
// (R11) host selects hi-z, releases dsp, waits 5 ms before play
// (R12) read/write reserved bits store data; read-only reserved reads zero
`timescale 1ns/10ps

module adc_device_control_regs (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire adc_pkg::adc_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  output adc_pkg::adc_ctrl_t ctrl,
  output logic core_reset_pulse,
  output logic coef_ram_clear,
  output logic mute_ramp_down,
  output logic mute_ramp_up
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0] reset_control_ff;
  logic [7:0] output_stage_config_ff;
  logic [7:0] power_state_control_ff;
  logic [7:0] nxt_reset_control;
  logic [7:0] nxt_output_stage_config;
  logic [7:0] nxt_power_state_control;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic core_reset_ff;
  logic nxt_core_reset;
  logic coef_clear_ff;
  logic nxt_coef_clear;
  logic mute_down_ff;
  logic nxt_mute_down;
  logic mute_up_ff;
  logic nxt_mute_up;
  logic wipe;
  // reserved switching codes flagged so the modulator can hold its last rate
  logic rate_flag_ff;
  logic nxt_rate_flag;

  function automatic logic hit(input adc_pkg::adc_req_t r, input logic [7:0] a);
    hit = r.wr_en && (r.addr == a);
  endfunction : hit

  function automatic logic rate_is_reserved(input logic [2:0] code);
    case (code)
      adc_pkg::RATE_768K, adc_pkg::RATE_384K,
      adc_pkg::RATE_480K, adc_pkg::RATE_576K: rate_is_reserved = 1'b0; // R4
      default: rate_is_reserved = 1'b1;
    endcase
  endfunction : rate_is_reserved

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_reset_control = reset_control_ff;
    nxt_output_stage_config = output_stage_config_ff;
    nxt_power_state_control = power_state_control_ff;
    nxt_core_reset = 1'b0;
    nxt_coef_clear = 1'b0;
    wipe = 1'b0;
    if (hit(req, adc_pkg::ADDR_RESET_CONTROL)) begin
      // only reserved r/w bits are stored; self-clearing bits never land
      nxt_reset_control = req.wdata & adc_pkg::RESET_CTRL_RW_MASK; // R12
      if (req.wdata[adc_pkg::CORE_RESET_BIT]) begin
        nxt_core_reset = 1'b1; // R1
        nxt_coef_clear = 1'b1; // R2
        wipe = 1'b1; // R1
      end else if (req.wdata[adc_pkg::REG_RESET_BIT]) begin
        wipe = 1'b1; // R3
      end
    end
    if (hit(req, adc_pkg::ADDR_OUTPUT_STAGE)) begin
      nxt_output_stage_config = req.wdata; // R4 R5 R6 R12
    end
    if (hit(req, adc_pkg::ADDR_POWER_STATE)) begin
      nxt_power_state_control = req.wdata; // R7 R9 R10 R12
    end
    // a register reset wins over data written in the same access
    if (wipe) begin
      nxt_reset_control = adc_pkg::RST_RESET_CONTROL; // R3
      nxt_output_stage_config = adc_pkg::RST_OUTPUT_STAGE; // R3
      nxt_power_state_control = adc_pkg::RST_POWER_STATE; // R3 R7
    end
  end

  // ------------------------------------------------------------
  // read path and derived pulses
  // ------------------------------------------------------------
  always_comb begin
    nxt_rvalid = req.rd_en;
    nxt_rdata = rdata_ff;
    if (req.rd_en) begin
      case (req.addr)
        adc_pkg::ADDR_RESET_CONTROL: nxt_rdata = reset_control_ff; // R12
        adc_pkg::ADDR_OUTPUT_STAGE: nxt_rdata = output_stage_config_ff;
        adc_pkg::ADDR_POWER_STATE: nxt_rdata = power_state_control_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
    // edge of the mute request starts a ramp in the volume stage
    nxt_mute_down = nxt_power_state_control[adc_pkg::MUTE_BIT]
                    && !power_state_control_ff[adc_pkg::MUTE_BIT]; // R9
    nxt_mute_up = !nxt_power_state_control[adc_pkg::MUTE_BIT]
                  && power_state_control_ff[adc_pkg::MUTE_BIT]; // R9
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_control_ff <= adc_pkg::RST_RESET_CONTROL;
      output_stage_config_ff <= adc_pkg::RST_OUTPUT_STAGE;
      power_state_control_ff <= adc_pkg::RST_POWER_STATE; // R7
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      core_reset_ff <= 1'b0;
      coef_clear_ff <= 1'b0;
      mute_down_ff <= 1'b0;
      mute_up_ff <= 1'b0;
    end else begin
      reset_control_ff <= nxt_reset_control;
      output_stage_config_ff <= nxt_output_stage_config;
      power_state_control_ff <= nxt_power_state_control;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      core_reset_ff <= nxt_core_reset;
      coef_clear_ff <= nxt_coef_clear;
      mute_down_ff <= nxt_mute_down;
      mute_up_ff <= nxt_mute_up;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // controls are fields of flip-flops; no gates after them
  assign ctrl.switching_rate_select = output_stage_config_ff[adc_pkg::RATE_LSB +: 3]; // R4
  assign ctrl.rate_reserved = rate_flag_ff;
  assign ctrl.bridge_parallel_select = output_stage_config_ff[adc_pkg::BRIDGE_BIT]; // R5
  assign ctrl.modulation_scheme = output_stage_config_ff[adc_pkg::MOD_LSB +: 2]; // R6
  assign ctrl.dsp_hold = power_state_control_ff[adc_pkg::DSP_HOLD_BIT]; // R7
  assign ctrl.mute = power_state_control_ff[adc_pkg::MUTE_BIT]; // R9
  assign ctrl.power_state = power_state_control_ff[adc_pkg::PSTATE_LSB +: 2]; // R10
  assign rdata = rdata_ff;
  assign rvalid = rvalid_ff;
  assign core_reset_pulse = core_reset_ff; // R1
  assign coef_ram_clear = coef_clear_ff; // R2
  assign mute_ramp_down = mute_down_ff;
  assign mute_ramp_up = mute_up_ff;

  always_comb begin
    nxt_rate_flag = rate_is_reserved(nxt_output_stage_config[adc_pkg::RATE_LSB +: 3]); // R4
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rate_flag_ff <= 1'b0;
    end else begin
      rate_flag_ff <= nxt_rate_flag;
    end
  end

endmodule : adc_device_control_regs

// *** verification/adc_regs_assertions.sv ***
`timescale 1ns/10ps
module adc_regs_checker (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire adc_pkg::adc_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire adc_pkg::adc_ctrl_t ctrl,
  input wire logic core_reset_pulse,
  input wire logic coef_ram_clear,
  input wire logic mute_ramp_down,
  input wire logic mute_ramp_up
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence core_wr_s;
    req.wr_en && req.addr == 8'h01 && req.wdata[4];
  endsequence
  sequence defaults_s;
    core_reset_pulse && ctrl.dsp_hold && !ctrl.mute && ctrl.power_state == 2'h0;
  endsequence
  core_reset_a: assert property (core_wr_s |=> defaults_s ##1 !core_reset_pulse)
    else $error("core reset not seen");
  ram_clear_a: assert property (coef_ram_clear == core_reset_pulse)
    else $error("ram clear apart from core reset");
  reg_reset_a: assert property (req.wr_en && req.addr == 8'h01 && req.wdata[0] |=> ctrl.dsp_hold && !ctrl.mute)
    else $error("register reset ignored");
  out_stage_a: assert property (req.wr_en && req.addr == 8'h02 |=> {ctrl.switching_rate_select,
    ctrl.bridge_parallel_select, ctrl.modulation_scheme} == $past({req.wdata[6:4], req.wdata[2:0]}))
    else $error("output stage fields wrong");
  rate_flag_a: assert property (req.wr_en && req.addr == 8'h02 |=>
    ctrl.rate_reserved == ($past(req.wdata[6:4]) inside {3'h2, 3'h5, 3'h6, 3'h7}))
    else $error("reserved rate flag wrong");
  power_field_a: assert property (req.wr_en && req.addr == 8'h03 |=> {ctrl.dsp_hold, ctrl.mute,
    ctrl.power_state} == $past({req.wdata[4:3], req.wdata[1:0]}))
    else $error("power control fields wrong");
  mute_down_a: assert property ($rose(ctrl.mute) |-> mute_ramp_down && !mute_ramp_up)
    else $error("no ramp down on mute");
  mute_up_a: assert property ($fell(ctrl.mute) |-> mute_ramp_up && !mute_ramp_down)
    else $error("no ramp up on unmute");
  ro_zero_a: assert property (req.rd_en && req.addr == 8'h01 |=> rvalid && rdata[4:0] == 5'h00)
    else $error("reset control low bits not zero");
endmodule : adc_regs_checker
bind adc_device_control_regs adc_regs_checker adc_regs_checker_inst (.sys_clk(sys_clk),
  .arst_n(arst_n), .req(req), .rdata(rdata), .rvalid(rvalid), .ctrl(ctrl),
  .core_reset_pulse(core_reset_pulse), .coef_ram_clear(coef_ram_clear),
  .mute_ramp_down(mute_ramp_down), .mute_ramp_up(mute_ramp_up));

// *** verification/adc_host_model.sv ***
`timescale 1ns/10ps
// settle wait is far shorter than the real audio clock settle time to keep runs short
module adc_host_model #(parameter int SETTLE_CYCLES = 16) (
  input wire logic sys_clk,
  input wire logic [7:0] rdata,
  output adc_pkg::adc_req_t req
);
  initial req = '0;
  // idle bus shows the inverse of the last value so stale data cannot pass
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 req = '{wr_en: w, rd_en: !w, addr: a, wdata: d};
    @(posedge sys_clk);
    #1 req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
  endtask : access
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    access(1'b1, a, d);
  endtask : write
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    access(1'b0, a, 8'h00);
    d = rdata;
  endtask : read
  task automatic startup;
    write(adc_pkg::ADDR_POWER_STATE, 8'h02);
    repeat (SETTLE_CYCLES) @(posedge sys_clk);
    write(adc_pkg::ADDR_POWER_STATE, 8'h03);
  endtask : startup
endmodule : adc_host_model

// *** verification/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  logic sys_clk;
  logic arst_n;
  adc_pkg::adc_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  adc_pkg::adc_ctrl_t ctrl;
  logic core_reset_pulse, coef_ram_clear, mute_ramp_down, mute_ramp_up;
  int fail_count = 0;
  int samples_checked = 0;
  logic [7:0] rv;
  adc_device_control_regs adc_device_control_regs_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .req(req), .rdata(rdata), .rvalid(rvalid), .ctrl(ctrl), .core_reset_pulse(core_reset_pulse),
    .coef_ram_clear(coef_ram_clear), .mute_ramp_down(mute_ramp_down), .mute_ramp_up(mute_ramp_up));
  adc_host_model adc_host_model_inst (.sys_clk(sys_clk), .rdata(rdata), .req(req));
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task results;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task t_defaults;
    for (int i = 1; i < 5; i++) begin
      adc_host_model_inst.read(8'(i), rv);
      check("default", rv, (i == 3) ? adc_pkg::RST_POWER_STATE : 8'h00);
      check("rvalid", {7'h00, rvalid}, 8'h01);
    end
    $display("defaults done");
  endtask : t_defaults
  task t_stage;
    logic [2:0] r;
    logic [1:0] m;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      r = i[2:0];
      m = 2'(i % 3);
      v = {r[0], r, r[1], r[0], m};
      adc_host_model_inst.write(adc_pkg::ADDR_OUTPUT_STAGE, v);
      check("rate", {5'h00, ctrl.switching_rate_select}, {5'h00, v[6:4]});
      check("rate_rsvd", {7'h00, ctrl.rate_reserved}, {7'h00, r inside {3'h2, 3'h5, 3'h6, 3'h7}});
      check("bridge_mod", {5'h00, ctrl.bridge_parallel_select, ctrl.modulation_scheme}, {5'h00, v[2:0]});
      adc_host_model_inst.read(adc_pkg::ADDR_OUTPUT_STAGE, rv);
      check("stage_rb", rv, v);
    end
    $display("output stage done");
  endtask : t_stage
  task t_power;
    logic [7:0] v;
    logic pm;
    adc_host_model_inst.startup();
    check("startup", {3'h0, ctrl.dsp_hold, ctrl.mute, 1'b0, ctrl.power_state}, 8'h03);
    pm = 1'b0;
    for (int i = 0; i < 4; i++) begin
      v = {4'h0, i[0], 1'b0, i[1:0]};
      adc_host_model_inst.write(adc_pkg::ADDR_POWER_STATE, v);
      check("pstate", {3'h0, ctrl.dsp_hold, ctrl.mute, 1'b0, ctrl.power_state}, v);
      check("ramp", {6'h00, mute_ramp_down, mute_ramp_up}, {6'h00, v[3] & !pm, !v[3] & pm});
      pm = v[3];
    end
    $display("power done");
  endtask : t_power
  task t_resets;
    adc_host_model_inst.write(adc_pkg::ADDR_RESET_CONTROL, 8'hEE);
    adc_host_model_inst.read(adc_pkg::ADDR_RESET_CONTROL, rv);
    check("rsvd_rw", rv, 8'hE0);
    adc_host_model_inst.write(adc_pkg::ADDR_OUTPUT_STAGE, 8'h55);
    adc_host_model_inst.write(adc_pkg::ADDR_RESET_CONTROL, 8'h00);
    adc_host_model_inst.read(adc_pkg::ADDR_OUTPUT_STAGE, rv);
    check("zero_write", rv, 8'h55);
    adc_host_model_inst.write(adc_pkg::ADDR_RESET_CONTROL, 8'h01);
    check("reg_rst_pulse", {6'h00, core_reset_pulse, coef_ram_clear}, 8'h00);
    adc_host_model_inst.read(adc_pkg::ADDR_OUTPUT_STAGE, rv);
    check("reg_rst_stage", rv, adc_pkg::RST_OUTPUT_STAGE);
    adc_host_model_inst.read(adc_pkg::ADDR_POWER_STATE, rv);
    check("reg_rst_power", rv, adc_pkg::RST_POWER_STATE);
    adc_host_model_inst.read(adc_pkg::ADDR_RESET_CONTROL, rv);
    check("self_clear", rv, 8'h00);
    adc_host_model_inst.write(adc_pkg::ADDR_POWER_STATE, 8'h0B);
    adc_host_model_inst.write(adc_pkg::ADDR_RESET_CONTROL, 8'h10);
    check("core_pulse", {6'h00, core_reset_pulse, coef_ram_clear}, 8'h03);
    check("core_defaults", {3'h0, ctrl.dsp_hold, ctrl.mute, 1'b0, ctrl.power_state}, 8'h10);
    @(posedge sys_clk);
    #1 check("core_once", {7'h00, core_reset_pulse}, 8'h00);
    $display("resets done");
  endtask : t_resets
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #20000;
    fail_count++;
    results();
  end
  initial begin
    arst_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    t_defaults();
    t_stage();
    t_power();
    t_resets();
    results();
  end
endmodule : testbench
